/* logic/uart_fc_pkg.sv */
// Package with constants and carrier types of the flow-controlled serial port.
//
// Contract
// - Sixteen-bit baud timer behind prescaler 1/4/12/48.
// - No transfer while baud generator disabled.
// - Timer counts up, reloads on FFFF wrap.
// - Bit rate is clock/((65536-reload)*2*prescale).
// - Start low, data LSB first, option, stop high.
// - Data length selectable 5, 6, 7 or 8.
// - Parity even/odd/mark/space generated and checked.
// - Stop short one bit, long 1.5 or 2.
// - No extra bit with parity; 2 stops 6-8.
// - CTS and RTS each work only when enabled.
// - CTS high halts after current byte.
// - RTS high while receive buffer full.
// - Data write starts transmission, LSB first.
// - Done flag at stop start; interrupt if enabled.
// - Receive enabled frames start on start condition.
// - Store only with room and filter passing.
// - Full buffer discards new byte, keeps old.
// - Ready flag set on push; interrupt if enabled.
// - Received extra or stop bit is readable.
// - Buffer byte counts always readable.
package uart_fc_pkg;

  // Prescaler select codes and their divide factors.
  localparam logic [1:0] PRESC_SEL_1 = 2'h0;
  localparam logic [1:0] PRESC_SEL_4 = 2'h1;
  localparam logic [1:0] PRESC_SEL_12 = 2'h2;
  localparam logic [1:0] PRESC_SEL_48 = 2'h3;
  localparam logic [5:0] PRESC_DIV_1 = 6'h01;
  localparam logic [5:0] PRESC_DIV_4 = 6'h04;
  localparam logic [5:0] PRESC_DIV_12 = 6'h0C;
  localparam logic [5:0] PRESC_DIV_48 = 6'h30;

  // Timer wrap point and reset values.
  localparam logic [15:0] TIMER_TOP = 16'hFFFF;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [5:0] PRESC_CNT_RST = 6'h00;

  // Data length codes: code 0 is five bits, code 3 is eight bits.
  localparam logic [1:0] LEN_5 = 2'h0;
  localparam logic [2:0] LEN_BASE_LAST = 3'h4;

  // Parity kind codes.
  localparam logic [1:0] PAR_ODD = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;

  // Stop lengths in half-bit ticks (the timer wraps twice per bit).
  localparam logic [2:0] STOP_SHORT_HALVES = 3'h2;
  localparam logic [2:0] STOP_MID_HALVES = 3'h3;
  localparam logic [2:0] STOP_LONG_HALVES = 3'h4;

  // Clock rate and the length of the input synchroniser.
  localparam int CLK_HZ = 50000000;
  localparam int SYNC_STAGES = 3;

  // Baud generator configuration (baud_control plus reload bytes).
  typedef struct packed {
    logic enable;
    logic [1:0] presc_sel;
    logic [7:0] reload_high;
    logic [7:0] reload_low;
  } baud_cfg_t;

  // Frame format configuration (serial_mode_reg fields).
  typedef struct packed {
    logic [1:0] data_len;
    logic parity_enable;
    logic [1:0] parity_kind;
    logic extra_bit_enable;
    logic stop_long;
    logic multiproc_filter_enable;
  } frame_cfg_t;

  // Readable byte counts of both buffers (buffer_count_reg).
  typedef struct packed {
    logic rx_count;
    logic tx_count;
  } buffer_count_t;

endpackage

/* logic/baud_tick_gen.sv */
// Prescaled 16-bit reload timer that emits one tick per half bit.
`timescale 1ns/1ps
module baud_tick_gen (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire uart_fc_pkg::baud_cfg_t i_cfg,
  input wire logic i_restart,
  output logic o_tick
);
  import uart_fc_pkg::*;

  logic [5:0] presc_cnt_reg; // Prescaler phase counter.
  logic [5:0] presc_div; // Selected divide factor.
  logic pre_tick; // One cycle per prescaled timer tick.
  logic [15:0] timer_reg; // Up-counting baud timer.
  logic [15:0] reload_value; // Joined baud_reload_value.

  assign reload_value = {i_cfg.reload_high, i_cfg.reload_low};

  // Decode the prescaler select into a divide factor.
  always_comb begin
    unique case (i_cfg.presc_sel)
      PRESC_SEL_1: presc_div = PRESC_DIV_1;
      PRESC_SEL_4: presc_div = PRESC_DIV_4;
      PRESC_SEL_12: presc_div = PRESC_DIV_12;
      PRESC_SEL_48: presc_div = PRESC_DIV_48;
    endcase
  end

  assign pre_tick = (presc_cnt_reg == presc_div - 6'h01);

  // Prescaler; a restart realigns it so a receiver can lock to an edge.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_cnt_reg <= PRESC_CNT_RST;
    end else if (!i_cfg.enable || i_restart || pre_tick) begin
      presc_cnt_reg <= PRESC_CNT_RST;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 6'h01;
    end
  end

  // Timer counts up and reloads on the wrap; two wraps make one bit.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_reg <= RELOAD_RST;
      o_tick <= 1'b0;
    end else if (!i_cfg.enable || i_restart) begin
      timer_reg <= reload_value;
      o_tick <= 1'b0;
    end else if (pre_tick) begin
      if (timer_reg == TIMER_TOP) begin
        timer_reg <= reload_value;
      end else begin
        timer_reg <= timer_reg + 16'h0001;
      end
      o_tick <= (timer_reg == TIMER_TOP);
    end else begin
      o_tick <= 1'b0;
    end
  end

  property p_timer_reload;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_cfg.enable && !i_restart && pre_tick && timer_reg == TIMER_TOP)
      |=> (timer_reg == $past(reload_value)) && o_tick;
  endproperty
  a_timer_reload: assert property (p_timer_reload)
    else $error("Baud timer did not reload on wrap.");

  property p_no_tick_disabled;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_cfg.enable |=> !o_tick;
  endproperty
  a_no_tick_disabled: assert property (p_no_tick_disabled)
    else $error("Baud tick while generator disabled.");

endmodule

/* logic/uart_fc_top.sv */
// Full-duplex serial port with baud generator, framing and flow control.
`timescale 1ns/1ps
module uart_fc_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire uart_fc_pkg::baud_cfg_t i_baud_cfg,
  input wire uart_fc_pkg::frame_cfg_t i_frame_cfg,
  input wire logic i_rx_enable,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_data_rd,
  input wire logic i_tx_extra_bit,
  input wire logic i_tx_done_clr,
  input wire logic i_rx_ready_clr,
  input wire logic i_parity_err_clr,
  input wire logic i_tx_irq_en,
  input wire logic i_rx_irq_en,
  input wire logic i_cts_enable,
  input wire logic i_rts_enable,
  input wire logic i_rx,
  input wire logic i_cts,
  output logic o_tx,
  output logic o_rts,
  output logic [7:0] o_data_rdata,
  output logic o_rx_extra_bit,
  output logic o_tx_done_flag,
  output logic o_rx_ready_flag,
  output logic o_parity_err_flag,
  output logic o_tx_irq,
  output logic o_rx_irq,
  output uart_fc_pkg::buffer_count_t o_buffer_count
);
  import uart_fc_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_NINTH = 5'h08,
    ST_STOP = 5'h10
  } frame_state_t;

  frame_state_t tx_state_reg; // Transmit sequencer state.
  frame_state_t rx_state_reg; // Receive sequencer state.
  logic tx_tick; // Free-running half-bit tick for the transmitter.
  logic rx_tick; // Half-bit tick realigned to each received start edge.
  logic rx_restart; // Start edge seen; realigns the receive timer.
  logic [2:0] rx_sync_reg; // Three-stage RX synchroniser.
  logic [2:0] cts_sync_reg; // Three-stage CTS synchroniser.
  logic rx_filt_reg; // Accepted RX level.
  logic rx_prev_reg; // Previous accepted RX level, for edge finding.
  logic cts_filt_reg; // Accepted CTS level.
  logic [2:0] last_idx; // Index of the final data bit.
  logic ninth_used; // Parity or extra bit present in the frame.
  logic [2:0] stop_halves; // Stop length in half-bit ticks.
  logic [7:0] tx_buf_reg; // Single-byte transmit holding buffer.
  logic tx_buf_extra_reg; // Extra bit captured with the byte.
  logic tx_buf_valid_reg; // Holding buffer occupied.
  logic [7:0] tx_shift_reg; // Byte on the wire.
  logic tx_ninth_reg; // Parity or extra bit on the wire.
  logic tx_phase_reg; // Second half of the current bit.
  logic [2:0] tx_idx_reg; // Transmit bit index or stop half count.
  logic tx_launch; // Holding buffer moves onto the wire.
  logic cts_block; // Remote party asks us to stop.
  logic [7:0] rx_shift_reg; // Byte being assembled.
  logic rx_ninth_reg; // Received parity or extra bit.
  logic rx_phase_reg; // Half-bit phase within a received bit.
  logic [2:0] rx_idx_reg; // Receive bit index.
  logic rx_done; // Stop bit sampled; frame complete.
  logic rx_tag_bit; // Extra bit or stop bit of the current frame.
  logic rx_filter_ok; // Multiprocessor filter lets the frame in.
  logic rx_push; // Frame enters the receive buffer.
  logic rx_full_reg; // Receive buffer occupied.
  logic [7:0] mask; // Keeps only the configured data bits.

  // Parity of the given data for the selected kind.
  function automatic logic parity_of(input logic [7:0] d,
                                     input logic [1:0] kind);
    logic p;
    p = ^d;
    unique case (kind)
      PAR_ODD: parity_of = ~p;
      PAR_EVEN: parity_of = p;
      PAR_MARK: parity_of = 1'b1;
      PAR_SPACE: parity_of = 1'b0;
    endcase
  endfunction

  // Transmit timer runs free; the receive one restarts on each start edge seen while idle.
  baud_tick_gen u_tx_baud (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_cfg(i_baud_cfg),
    .i_restart(1'b0),
    .o_tick(tx_tick)
  );

  baud_tick_gen u_rx_baud (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_cfg(i_baud_cfg),
    .i_restart(rx_restart),
    .o_tick(rx_tick)
  );

  // Frame shape: length, optional ninth bit and stop length.
  assign last_idx = LEN_BASE_LAST + {1'b0, i_frame_cfg.data_len};
  // The extra bit is ignored while parity is on.
  assign ninth_used = i_frame_cfg.parity_enable
                    | i_frame_cfg.extra_bit_enable;
  // A five-bit frame gets 1.5 stops when long, the others get two.
  always_comb begin
    if (!i_frame_cfg.stop_long) begin
      stop_halves = STOP_SHORT_HALVES;
    end else if (i_frame_cfg.data_len == LEN_5) begin
      stop_halves = STOP_MID_HALVES;
    end else begin
      stop_halves = STOP_LONG_HALVES;
    end
  end
  assign mask = 8'hFF >> (3'h7 - last_idx);

  // Both pins pass three flops; a level is accepted once the last two stages agree.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_sync_reg <= 3'h7;
      cts_sync_reg <= 3'h0;
      rx_filt_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
      cts_filt_reg <= 1'b0;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], i_rx};
      cts_sync_reg <= {cts_sync_reg[1:0], i_cts};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_filt_reg <= rx_sync_reg[2];
      end
      if (cts_sync_reg[1] == cts_sync_reg[2]) begin
        cts_filt_reg <= cts_sync_reg[2];
      end
      rx_prev_reg <= rx_filt_reg;
    end
  end

  // CTS only matters when routed in; it is checked between bytes only.
  assign cts_block = i_cts_enable & cts_filt_reg;
  assign tx_launch = (tx_state_reg == ST_IDLE) & tx_buf_valid_reg
                   & i_baud_cfg.enable & !cts_block & tx_tick;

  // Holding buffer; a write while full overwrites the waiting byte.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_buf_reg <= 8'h00;
      tx_buf_extra_reg <= 1'b0;
      tx_buf_valid_reg <= 1'b0;
    end else if (i_data_wr) begin
      tx_buf_reg <= i_data_wdata;
      tx_buf_extra_reg <= i_tx_extra_bit;
      tx_buf_valid_reg <= 1'b1;
    end else if (tx_launch) begin
      tx_buf_valid_reg <= 1'b0;
    end
  end

  // Transmit sequencer; the line level is registered with the state.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state_reg <= ST_IDLE;
      o_tx <= 1'b1;
      tx_shift_reg <= 8'h00;
      tx_ninth_reg <= 1'b0;
      tx_phase_reg <= 1'b0;
      tx_idx_reg <= 3'h0;
    end else if (!i_baud_cfg.enable) begin
      tx_state_reg <= ST_IDLE;
      o_tx <= 1'b1;
    end else if (tx_launch) begin
      tx_state_reg <= ST_START;
      o_tx <= 1'b0;
      tx_shift_reg <= tx_buf_reg & mask;
      tx_ninth_reg <= i_frame_cfg.parity_enable
                    ? parity_of(tx_buf_reg & mask, i_frame_cfg.parity_kind)
                    : tx_buf_extra_reg;
      tx_phase_reg <= 1'b0;
      tx_idx_reg <= 3'h0;
    end else if (tx_tick && tx_state_reg != ST_IDLE) begin
      tx_phase_reg <= ~tx_phase_reg;
      unique case (tx_state_reg)
        ST_START: begin
          if (tx_phase_reg) begin
            tx_state_reg <= ST_DATA;
            o_tx <= tx_shift_reg[0];
          end
        end
        ST_DATA: begin
          if (tx_phase_reg && tx_idx_reg == last_idx) begin
            tx_idx_reg <= 3'h1;
            tx_state_reg <= ninth_used ? ST_NINTH : ST_STOP;
            o_tx <= ninth_used ? tx_ninth_reg : 1'b1;
          end else if (tx_phase_reg) begin
            tx_idx_reg <= tx_idx_reg + 3'h1;
            o_tx <= tx_shift_reg[tx_idx_reg + 3'h1];
          end
        end
        ST_NINTH: begin
          if (tx_phase_reg) begin
            tx_state_reg <= ST_STOP;
            o_tx <= 1'b1;
          end
        end
        default: begin
          // Stop period counted in halves so 1.5 bits is possible.
          if (tx_idx_reg >= stop_halves) begin
            tx_state_reg <= ST_IDLE;
          end
          tx_idx_reg <= tx_idx_reg + 3'h1;
        end
      endcase
    end
  end

  // Done flag rises as the stop bit starts; a same-cycle clear loses.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_done_flag <= 1'b0;
    end else if (tx_tick && tx_phase_reg && i_baud_cfg.enable &&
                 ((tx_state_reg == ST_DATA && tx_idx_reg == last_idx &&
                   !ninth_used) || tx_state_reg == ST_NINTH)) begin
      o_tx_done_flag <= 1'b1;
    end else if (i_tx_done_clr) begin
      o_tx_done_flag <= 1'b0;
    end
  end

  assign rx_restart = (rx_state_reg == ST_IDLE) & i_rx_enable
                    & i_baud_cfg.enable & !rx_filt_reg
                    & rx_prev_reg;
  assign rx_done = (rx_state_reg == ST_STOP) & rx_tick & rx_phase_reg;
  assign rx_tag_bit = i_frame_cfg.extra_bit_enable
                    & !i_frame_cfg.parity_enable
                    ? rx_ninth_reg : rx_filt_reg;
  assign rx_filter_ok = !i_frame_cfg.multiproc_filter_enable
                      | rx_tag_bit;
  assign rx_push = rx_done & !rx_full_reg & rx_filter_ok;

  // Receive sequencer; the start bit is rechecked half a bit in.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_state_reg <= ST_IDLE;
      rx_shift_reg <= 8'h00;
      rx_ninth_reg <= 1'b0;
      rx_phase_reg <= 1'b0;
      rx_idx_reg <= 3'h0;
    end else if (!i_baud_cfg.enable) begin
      rx_state_reg <= ST_IDLE;
    end else if (rx_restart) begin
      rx_state_reg <= ST_START;
      rx_shift_reg <= 8'h00;
      rx_idx_reg <= 3'h0;
    end else if (rx_tick) begin
      unique case (rx_state_reg)
        ST_START: begin
          // A glitch shorter than half a bit is dropped here.
          rx_state_reg <= rx_filt_reg ? ST_IDLE : ST_DATA;
          rx_phase_reg <= 1'b0;
        end
        ST_DATA: begin
          rx_phase_reg <= ~rx_phase_reg;
          if (rx_phase_reg) begin
            rx_shift_reg[rx_idx_reg] <= rx_filt_reg;
            rx_idx_reg <= rx_idx_reg + 3'h1;
            if (rx_idx_reg == last_idx) begin
              rx_state_reg <= ninth_used ? ST_NINTH : ST_STOP;
            end
          end
        end
        ST_NINTH: begin
          rx_phase_reg <= ~rx_phase_reg;
          if (rx_phase_reg) begin
            rx_ninth_reg <= rx_filt_reg;
            rx_state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          rx_phase_reg <= ~rx_phase_reg;
          if (rx_phase_reg) begin
            rx_state_reg <= ST_IDLE;
          end
        end
        default: begin
          rx_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive buffer; a full buffer keeps its byte and drops the new one.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_full_reg <= 1'b0;
      o_data_rdata <= 8'h00;
      o_rx_extra_bit <= 1'b0;
    end else if (rx_push) begin
      rx_full_reg <= 1'b1;
      o_data_rdata <= rx_shift_reg;
      o_rx_extra_bit <= rx_tag_bit;
    end else if (i_data_rd) begin
      rx_full_reg <= 1'b0; // Reads while empty return the old byte.
    end
  end

  // Ready and parity error flags; hardware setting beats clearing.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_ready_flag <= 1'b0;
      o_parity_err_flag <= 1'b0;
    end else begin
      if (rx_push) begin
        o_rx_ready_flag <= 1'b1;
      end else if (i_rx_ready_clr) begin
        o_rx_ready_flag <= 1'b0;
      end
      if (rx_push && i_frame_cfg.parity_enable &&
          rx_ninth_reg != parity_of(rx_shift_reg & mask,
                                    i_frame_cfg.parity_kind)) begin
        o_parity_err_flag <= 1'b1;
      end else if (i_parity_err_clr) begin
        o_parity_err_flag <= 1'b0;
      end
    end
  end

  // RTS is asserted only when routed out and the buffer is full.
  assign o_rts = i_rts_enable & rx_full_reg;
  assign o_tx_irq = o_tx_done_flag & i_tx_irq_en;
  assign o_rx_irq = o_rx_ready_flag & i_rx_irq_en;
  assign o_buffer_count = '{rx_count: rx_full_reg,
                            tx_count: tx_buf_valid_reg};

  property p_start_low;
    @(posedge i_clk) disable iff (!i_rst_n)
    tx_launch |=> (tx_state_reg == ST_START) && !o_tx;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("Launch did not drive a low start bit.");

  property p_done_at_stop;
    @(posedge i_clk) disable iff (!i_rst_n)
    (tx_state_reg == ST_STOP) && ($past(tx_state_reg) != ST_STOP)
      |-> o_tx_done_flag && o_tx;
  endproperty
  a_done_at_stop: assert property (p_done_at_stop)
    else $error("Done flag missing at stop start.");

  property p_cts_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    (tx_state_reg == ST_IDLE) && cts_block |=> tx_state_reg == ST_IDLE;
  endproperty
  a_cts_hold: assert property (p_cts_hold)
    else $error("Byte started while CTS asked to halt.");

  property p_disabled_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_baud_cfg.enable |=> (tx_state_reg == ST_IDLE)
                           && (rx_state_reg == ST_IDLE) && o_tx;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("Port active with baud generator disabled.");

  property p_overrun_keeps;
    @(posedge i_clk) disable iff (!i_rst_n)
    rx_done && rx_full_reg && !i_data_rd
      |=> $stable(o_data_rdata) && rx_full_reg;
  endproperty
  a_overrun_keeps: assert property (p_overrun_keeps)
    else $error("Buffered byte changed on overrun.");

  property p_push_flags;
    @(posedge i_clk) disable iff (!i_rst_n)
    rx_push |=> o_rx_ready_flag && (o_rts == i_rts_enable)
                && o_buffer_count.rx_count;
  endproperty
  a_push_flags: assert property (p_push_flags)
    else $error("Push did not set ready, RTS or count.");

  property p_filter_drop;
    @(posedge i_clk) disable iff (!i_rst_n)
    rx_done && !rx_full_reg && i_frame_cfg.multiproc_filter_enable
      && !rx_tag_bit |=> !rx_full_reg;
  endproperty
  a_filter_drop: assert property (p_filter_drop)
    else $error("Filtered frame entered the buffer.");

  property p_start_confirm;
    @(posedge i_clk) disable iff (!i_rst_n)
    (rx_state_reg == ST_START) && rx_tick && rx_filt_reg
      && i_baud_cfg.enable |=> rx_state_reg == ST_IDLE;
  endproperty
  a_start_confirm: assert property (p_start_confirm)
    else $error("False start bit was accepted.");

  c_tx_frame: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    (tx_state_reg == ST_STOP) ##1 (tx_state_reg == ST_IDLE));
  c_rx_push: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    rx_push);
  c_cts_wait: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    tx_buf_valid_reg && cts_block && tx_state_reg == ST_IDLE);
  c_overrun: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    rx_done && rx_full_reg);

endmodule

/* sim/remote_uart.sv */
// Remote serial transceiver that faces the port across its pins.
`timescale 1ns/1ps
module remote_uart (
  input wire logic i_line,
  output logic o_line,
  output logic o_cts
);
  // Bit time in ns; the bench matches it to the port's setting.
  int bit_ns = 640;
  // The line idles high and CTS starts low, so the port may send.
  initial begin
    o_line = 1'b1;
    o_cts = 1'b0;
  end
  // Drives the flow-control input of the port.
  task automatic set_cts(input logic v);
    o_cts = v;
  endtask
  // Sends a low start, n bits LSB first, then a high stop.
  task automatic send(input logic [8:0] b, input int n);
    o_line = 1'b0;
    #(bit_ns);
    for (int i = 0; i < n; i++) begin
      o_line = b[i];
      #(bit_ns);
    end
    o_line = 1'b1;
    #(bit_ns);
  endtask
  // Waits for a start bit and samples n bits at their middles.
  task automatic recv(output logic [9:0] b, input int n);
    b = '0;
    @(negedge i_line);
    #(bit_ns / 2);
    for (int i = 0; i < n; i++) begin
      #(bit_ns);
      b[i] = i_line;
    end
  endtask
endmodule

/* sim/test_uart_fc_top.sv */
// Self-checking bench of the flow-controlled serial port.
`timescale 1ns/1ps
module test_uart_fc_top;
  import uart_fc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  // Enable stays low through reset so both timers load the reload value.
  baud_cfg_t bc = {1'b0, 2'h0, 16'hFFF0};
  frame_cfg_t fc = 8'hC0;
  logic wr = 1'b0, rd = 1'b0, tclr = 1'b0, rclr = 1'b0, cts_en = 1'b0;
  logic rx_en = 1'b1, txb = 1'b0, pclr = 1'b0, rts_en = 1'b1;
  logic [7:0] wd = 8'h00;
  wire tx, rts, rx, cts, rxb, tdone, rrdy, perr, tirq, rirq;
  wire [7:0] rdata;
  buffer_count_t cnt;
  int bad_count = 0;
  int samples_checked = 0;
  int dv[4] = '{1, 4, 12, 48};
  always #10 i_clk = ~i_clk;
  uart_fc_top uart_fc_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_baud_cfg(bc), .i_frame_cfg(fc), .i_rx_enable(rx_en),
    .i_data_wr(wr), .i_data_wdata(wd), .i_data_rd(rd),
    .i_tx_extra_bit(txb), .i_tx_done_clr(tclr), .i_rx_ready_clr(rclr),
    .i_parity_err_clr(pclr), .i_tx_irq_en(1'b1), .i_rx_irq_en(1'b1),
    .i_cts_enable(cts_en), .i_rts_enable(rts_en), .i_rx(rx), .i_cts(cts),
    .o_tx(tx), .o_rts(rts), .o_data_rdata(rdata), .o_rx_extra_bit(rxb),
    .o_tx_done_flag(tdone), .o_rx_ready_flag(rrdy),
    .o_parity_err_flag(perr), .o_tx_irq(tirq), .o_rx_irq(rirq),
    .o_buffer_count(cnt));
  remote_uart remote_uart_inst (.i_line(tx), .o_line(rx), .o_cts(cts));
  // Counts one comparison and reports it at once when it fails.
  task automatic check(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Writes one byte with a single-cycle strobe.
  task automatic wr_byte(input logic [7:0] d);
    @(negedge i_clk);
    wd = d;
    wr = 1'b1;
    @(negedge i_clk);
    wr = 1'b0;
  endtask
  // Pulses all three flag clears; the flags must then read low.
  task automatic clr();
    @(negedge i_clk);
    {tclr, rclr, pclr} = 3'h7;
    @(negedge i_clk);
    {tclr, rclr, pclr} = 3'h0;
    tick(1);
    check(tdone === 1'b0 && rrdy === 1'b0 && perr === 1'b0, "flag clear");
  endtask
  // Sends one byte and compares the frame that the remote end decodes.
  task automatic tx_case(input logic [1:0] c, input logic pe,
                         input logic [1:0] pk, input logic [7:0] d);
    logic [9:0] got;
    logic [9:0] e;
    int n;
    n = c + 5;
    e = {2'b00, d} & ((10'h001 << n) - 10'h001);
    fc.data_len = c;
    fc.parity_enable = pe;
    fc.parity_kind = pk;
    if (pe) begin
      e[n] = (pk == PAR_ODD) ? ~^e : (pk == PAR_EVEN) ? ^e : pk == PAR_MARK;
      n++;
    end else if (fc.extra_bit_enable) begin
      e[n] = txb;
      n++;
    end
    e[n] = 1'b1;
    fork
      remote_uart_inst.recv(got, n + 1);
      wr_byte(d);
    join
    check(got === e, "tx frame");
    check(tdone === 1'b1 && tirq === 1'b1, "tx done");
    clr();
  endtask
  // Receives one frame; a full buffer must keep the older byte.
  task automatic rx_case(input logic [8:0] b, input int n,
    input logic [7:0] ed, input logic st, input logic rdb);
    remote_uart_inst.send(b, n);
    tick(2);
    check(rrdy === st && rirq === st, "rx ready");
    check(cnt.rx_count === st && rts === (st & rts_en),
          "rx count");
    if (st) check(rdata === ed && rxb === 1'b1, "rx data");
    if (rdb) begin
      @(negedge i_clk);
      rd = 1'b1;
      @(negedge i_clk);
      rd = 1'b0;
      tick(1);
      check(rts === 1'b0 && cnt.rx_count === 1'b0, "rx read");
      clr();
    end
  endtask
  // Sends two zero bytes back to back; the line stays high for the stop
  // halves plus the half bit that the next launch waits for.
  task automatic stop_case(input logic [1:0] c, input int halves);
    time t0;
    fc.data_len = c;
    fc.parity_enable = 1'b0;
    fc.stop_long = 1'b1;
    fork
      wr_byte(8'h00);
      @(negedge tx);
    join
    wr_byte(8'h00);
    @(posedge tx);
    t0 = $time;
    @(negedge tx);
    check($time - t0 == 320 * (halves + 1), "stop length");
    @(posedge tx);
    clr();
  endtask
  // Holds a byte back by CTS or by the baud enable, then lets it go.
  task automatic held(input logic by_cts);
    logic [9:0] got;
    cts_en = by_cts;
    remote_uart_inst.set_cts(1'b1);
    bc.enable = by_cts;
    fork
      remote_uart_inst.recv(got, 9);
      begin
        wr_byte(8'h96);
        tick(100);
        check(tx === 1'b1 && cnt.tx_count === 1'b1, "tx held");
        remote_uart_inst.set_cts(1'b0);
        bc.enable = 1'b1;
      end
    join
    check(got === 10'h196, "tx resumed");
    clr();
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized well beyond the slowest prescaler frames.
  initial begin
    #1500000;
    bad_count++;
    summarize();
  end
  // Main sequence: reset, rates, formats, flow control, reception.
  initial begin
    tick(20);
    i_rst_n = 1'b1;
    tick(2);
    check(tx === 1'b1 && rts === 1'b0 && cnt === 2'h0 && tdone === 1'b0,
          "reset state");
    bc.enable = 1'b1;
    for (int s = 0; s < 4; s++) begin
      bc.presc_sel = 2'(s);
      remote_uart_inst.bit_ns = 640 * dv[s];
      tx_case(2'h3, 1'b0, 2'h0, 8'h5A);
    end
    bc.presc_sel = 2'h0;
    remote_uart_inst.bit_ns = 640;
    for (int k = 0; k < 4; k++) begin
      tx_case(2'(k), 1'b0, 2'h0, 8'hC5);
      tx_case(2'(k), 1'b1, 2'(k), 8'hB3 ^ 8'(k));
    end
    stop_case(2'h3, int'(STOP_LONG_HALVES));
    stop_case(2'h0, int'(STOP_MID_HALVES));
    fc = 8'hC4;
    txb = 1'b1;
    tx_case(2'h3, 1'b0, 2'h0, 8'h3C);
    fc = 8'hC0;
    held(1'b1);
    held(1'b0);
    rx_en = 1'b0;
    rx_case(9'h0A5, 8, 8'h00, 1'b0, 1'b0);
    rx_en = 1'b1;
    rx_case(9'h0A5, 8, 8'hA5, 1'b1, 1'b0);
    rx_case(9'h03C, 8, 8'hA5, 1'b1, 1'b1);
    fc.extra_bit_enable = 1'b1;
    fc.multiproc_filter_enable = 1'b1;
    rx_case(9'h055, 9, 8'h00, 1'b0, 1'b0);
    rx_case(9'h1C3, 9, 8'hC3, 1'b1, 1'b1);
    fc = 8'hE8;
    rx_case(9'h1A5, 9, 8'hA5, 1'b1, 1'b0);
    check(perr === 1'b1, "parity error");
    rts_en = 1'b0;
    rx_case(9'h0A5, 9, 8'hA5, 1'b1, 1'b1);
    summarize();
  end
endmodule
